// >>> hw/ctw_dual_timer.sv
// Purpose: 16-bit and 8-bit down-counter/timers with transmit and demodulation modes
// Assumes: Register port is synchronous; edge_in is synchronous to clk
// Notes: Timer events win over a same-cycle software clear of their flags
`timescale 1ns/1ps
`include "ctw_map.svh"

// Summary of operation
// (RL1) Demod: edge-once 0 captures/reloads every edge; 1 only the first edge.
// (RL2) Wide timeout flag sets at terminal count; writing 1 clears it.
// (RL3) Capture mask set: wide capture raises interrupt request.
// (RL4) Counter mask set: wide terminal count raises interrupt request.
// (RL5) Pin select bit picks port value or wide timer waveform.
// (RL6) Clock select sets the wide timer count rate.
// (RL7) Enable bit 7 reads wide running state; write 1 starts, 0 stops.
// (RL8) Enable bit 6 reads narrow running state; write 1 starts, 0 stops.
// (RL9) Bit 5 is read/write sync mode; counters then run together.
// (RL10) Demod narrow edge: capture low/high by polarity, flag, interrupt, reload FFh.
// (RL11) Demod narrow at zero: timeout flag, interrupt, continue from FFh.
// (RL12) Transmit, wide disabled: output is inverse of initial level bit.
// (RL13) Force field 10 or 11 drives wide output 0 or 1 always.
// (RL14) Wide enable loads combined reload bytes and sets initial output level.
// (RL15) Wide at zero: timeout flag, interrupt, toggle output in transmit.
// (RL16) After zero: single-pass stops in transmit; modulo-N, or any pass in demod, reloads and continues.
// (RL17) Reload bytes may change anytime; used at next load only.
// (RL18) Pin routing by shared route field plus one bit per timer control.
// (RL19) Software stops timers before switching transmit/demod modes.
// (RL20) Wide control bit positions are fixed by this design.
// (RL21) Global interrupt enable off keeps flags but suppresses requests.
module ctw_dual_timer (
  input wire logic clk, // System clock, 50 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes state when low
  input ctw_pkg::ctw_bus_t bus, // Register write/read request
  output logic [7:0] rdata, // Read data, updated on bus.rd
  input wire logic edge_in, // Demodulation edge input
  input wire logic [2:0] port_val, // Ordinary port values for the three pins
  input wire logic gie, // Global interrupt enable
  output logic [2:0] pin_out, // Output pins: narrow, wide, shared
  output logic irq_wide, // Wide timer interrupt request pulse
  output logic irq_narrow // Narrow timer interrupt request pulse
);

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] rsync_reg;
  logic rst_n;
  ctw_pkg::ctw_narrow_ctl_t nctl_reg, nctl_next;
  ctw_pkg::ctw_shared_ctl_t sctl_reg, sctl_next;
  ctw_pkg::ctw_wide_ctl_t wctl_reg, wctl_next;
  ctw_pkg::ctw_run_t wst_reg, wst_next;
  logic sync_reg, sync_next;
  logic nrun_reg, nrun_next;
  logic [15:0] wcnt_reg, wcnt_next;
  logic [7:0] ncnt_reg, ncnt_next;
  logic [7:0] rlh_reg, rlh_next;
  logic [7:0] rll_reg, rll_next;
  logic [15:0] wcap_reg, wcap_next;
  logic [7:0] ncl_reg, ncl_next;
  logic [7:0] nch_reg, nch_next;
  logic wwave_reg, wwave_next;
  logic nwave_reg, nwave_next;
  logic edge_reg;
  logic [7:0] rd_reg, rd_next;
  logic [2:0] pin_reg, pin_next;
  logic irqw_reg, irqw_next;
  logic irqn_reg, irqn_next;
  logic wtick, wr_ens, run_w, run_n, ntick, pos_e, neg_e, wout, nen;
  logic wcap_ev, wtout_ev, ncap_pos, nwrap_ev;
  logic [15:0] reload;
  logic [7:0] d;

  assign rst_n = rsync_reg[1];
  assign rdata = rd_reg;
  assign pin_out = pin_reg;
  assign irq_wide = irqw_reg;
  assign irq_narrow = irqn_reg;

  function automatic logic keep_flag(input logic flag, input logic wr1);
    return flag & ~wr1;
  endfunction

  ctw_tick u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .run(wst_reg != ctw_pkg::CTW_STOPPED),
    .sel(wctl_reg.clk_sel), // [RL6]
    .tick(wtick)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nctl_next = nctl_reg;
    sctl_next = sctl_reg;
    wctl_next = wctl_reg;
    wst_next = wst_reg;
    sync_next = sync_reg;
    nrun_next = nrun_reg;
    wcnt_next = wcnt_reg;
    ncnt_next = ncnt_reg;
    rlh_next = rlh_reg;
    rll_next = rll_reg;
    wcap_next = wcap_reg;
    ncl_next = ncl_reg;
    nch_next = nch_reg;
    wwave_next = wwave_reg;
    nwave_next = nwave_reg;
    rd_next = rd_reg;
    irqw_next = 1'b0;
    irqn_next = 1'b0;
    nen = 1'b0;
    d = bus.wdata;
    reload = {rlh_reg, rll_reg}; // [RL14] [RL17]
    wr_ens = bus.wr && (bus.addr == `CTW_A_ENS);
    // Software writes; clears applied first so events below win
    if (bus.wr) begin
      case (bus.addr)
        `CTW_A_NCTL: begin
          nctl_next.pin_sel = d[0]; // [RL18]
          nctl_next.tout_ie = d[1];
          nctl_next.cap_ie = d[2];
          nctl_next.tout = keep_flag(nctl_reg.tout, d[`CTW_B_TOUT]);
        end
        `CTW_A_SCTL: begin
          sctl_next.demod = d[7];
          sctl_next.alt = d[6];
          sctl_next.route = d[5:4]; // [RL18]
          sctl_next.force_out = d[3:2];
          if (sctl_reg.demod) begin
            sctl_next.pos_st = keep_flag(sctl_reg.pos_st, d[`CTW_B_POS]);
            sctl_next.lvl_neg = keep_flag(sctl_reg.lvl_neg, d[`CTW_B_NEG]);
          end else begin
            sctl_next.pos_st = d[`CTW_B_POS];
            sctl_next.lvl_neg = d[`CTW_B_NEG];
          end
        end
        `CTW_A_WCTL: begin
          wctl_next = d; // [RL20]
          wctl_next.tout = keep_flag(wctl_reg.tout, d[`CTW_B_TOUT]); // [RL2]
        end
        `CTW_A_ENS: begin
          sync_next = d[`CTW_B_SYNC]; // [RL9]
          if (d[`CTW_B_WEN] && wst_reg == ctw_pkg::CTW_STOPPED) begin // [RL7]
            wst_next = ctw_pkg::CTW_COUNTING;
            wcnt_next = reload; // [RL14]
            wwave_next = sctl_reg.lvl_neg;
          end else if (!d[`CTW_B_WEN]) begin
            wst_next = ctw_pkg::CTW_STOPPED;
          end
          nen = sync_next ? d[`CTW_B_WEN] : d[`CTW_B_NEN]; // [RL8] [RL9]
          if (nen && !nrun_reg) begin
            nrun_next = 1'b1;
            ncnt_next = `CTW_N_RELOAD;
          end else if (!nen) begin
            nrun_next = 1'b0;
          end
        end
        `CTW_A_RLH: rlh_next = d; // [RL17]
        `CTW_A_RLL: rll_next = d;
        default: ;
      endcase
    end
    // Wide timer events
    pos_e = edge_in && !edge_reg;
    neg_e = !edge_in && edge_reg;
    run_w = (wst_reg != ctw_pkg::CTW_STOPPED) && !wr_ens;
    wcap_ev = run_w && sctl_reg.demod && (pos_e || neg_e)
      && wst_reg == ctw_pkg::CTW_COUNTING; // [RL1]
    wtout_ev = run_w && !wcap_ev && wtick && wcnt_reg == `CTW_N_ZERO16;
    if (wcap_ev) begin
      wcap_next = wcnt_reg;
      wcnt_next = reload;
      irqw_next = wctl_reg.cap_ie; // [RL3]
      if (wctl_reg.edge_once) begin
        wst_next = ctw_pkg::CTW_LATCHED; // [RL1]
      end
    end else if (wtout_ev) begin
      wctl_next.tout = 1'b1; // [RL2] [RL15]
      irqw_next = wctl_reg.cnt_ie; // [RL4]
      if (!sctl_reg.demod) begin
        wwave_next = !wwave_reg; // [RL15]
      end
      if (wctl_reg.modulo || sctl_reg.demod) begin
        wcnt_next = reload; // [RL16]
      end else begin
        wst_next = ctw_pkg::CTW_STOPPED; // [RL16]
      end
    end else if (run_w && wtick) begin
      wcnt_next = wcnt_reg - 16'h0001;
    end
    // Narrow timer events
    run_n = nrun_reg && !wr_ens;
    ntick = sync_reg ? wtick : 1'b1; // [RL9]
    ncap_pos = run_n && sctl_reg.demod && pos_e;
    nwrap_ev = run_n && !(sctl_reg.demod && (pos_e || neg_e)) && ntick
      && ncnt_reg == `CTW_N_ZERO8;
    if (run_n && sctl_reg.demod && (pos_e || neg_e)) begin
      if (pos_e) begin
        ncl_next = ncnt_reg; // [RL10]
        sctl_next.pos_st = 1'b1;
      end else begin
        nch_next = ncnt_reg; // [RL10]
        sctl_next.lvl_neg = 1'b1;
      end
      irqn_next = nctl_reg.cap_ie;
      ncnt_next = `CTW_N_RELOAD; // [RL10]
    end else if (nwrap_ev) begin
      nctl_next.tout = 1'b1; // [RL11]
      irqn_next = nctl_reg.tout_ie;
      ncnt_next = `CTW_N_RELOAD; // [RL11]
      if (!sctl_reg.demod) begin
        nwave_next = !nwave_reg;
      end
    end else if (run_n && ntick) begin
      ncnt_next = ncnt_reg - 8'h01;
    end
    irqw_next = irqw_next && gie; // [RL21]
    irqn_next = irqn_next && gie; // [RL21]
    // Output waveform and pin routing
    if (sctl_reg.force_out[1]) begin
      wout = sctl_reg.force_out[0]; // [RL13]
    end else if (wst_reg == ctw_pkg::CTW_STOPPED && !sctl_reg.demod) begin
      wout = !sctl_reg.lvl_neg; // [RL12]
    end else begin
      wout = wwave_reg;
    end
    pin_next[0] = nctl_reg.pin_sel ? nwave_reg : port_val[0]; // [RL18]
    pin_next[1] = wctl_reg.pin_sel ? wout : port_val[1]; // [RL5]
    unique case (sctl_reg.route)
      `CTW_R_PORT: pin_next[2] = port_val[2];
      `CTW_R_NARROW: pin_next[2] = nwave_reg;
      `CTW_R_WIDE: pin_next[2] = wout;
      `CTW_R_BOTH: pin_next[2] = nwave_reg ^ wout; // [RL18]
    endcase
    // Read port
    if (bus.rd) begin
      case (bus.addr)
        `CTW_A_NCTL: rd_next = nctl_reg;
        `CTW_A_SCTL: rd_next = sctl_reg;
        `CTW_A_WCTL: rd_next = wctl_reg;
        `CTW_A_ENS: rd_next = {wst_reg != ctw_pkg::CTW_STOPPED, nrun_reg,
                               sync_reg, `CTW_N_ENS_LOW}; // [RL7] [RL8]
        `CTW_A_RLH: rd_next = rlh_reg;
        `CTW_A_RLL: rd_next = rll_reg;
        `CTW_A_WCL: rd_next = wcap_reg[7:0];
        `CTW_A_WCH: rd_next = wcap_reg[15:8];
        `CTW_A_NCL: rd_next = ncl_reg;
        `CTW_A_NCH: rd_next = nch_reg;
        default: rd_next = `CTW_N_ZERO8;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsync_reg <= 2'b00;
    end else begin
      rsync_reg <= {rsync_reg[0], 1'b1};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nctl_reg <= '0;
      sctl_reg <= '0;
      wctl_reg <= '0;
      wst_reg <= ctw_pkg::CTW_STOPPED;
      sync_reg <= 1'b0;
      nrun_reg <= 1'b0;
      wcnt_reg <= `CTW_N_ZERO16;
      ncnt_reg <= `CTW_N_ZERO8;
      rlh_reg <= `CTW_N_ZERO8;
      rll_reg <= `CTW_N_ZERO8;
      wcap_reg <= `CTW_N_ZERO16;
      ncl_reg <= `CTW_N_ZERO8;
      nch_reg <= `CTW_N_ZERO8;
      wwave_reg <= 1'b0;
      nwave_reg <= 1'b0;
      edge_reg <= 1'b0;
      rd_reg <= `CTW_N_ZERO8;
      pin_reg <= 3'h0;
      irqw_reg <= 1'b0;
      irqn_reg <= 1'b0;
    end else if (ce) begin
      nctl_reg <= nctl_next;
      sctl_reg <= sctl_next;
      wctl_reg <= wctl_next;
      wst_reg <= wst_next;
      sync_reg <= sync_next;
      nrun_reg <= nrun_next;
      wcnt_reg <= wcnt_next;
      ncnt_reg <= ncnt_next;
      rlh_reg <= rlh_next;
      rll_reg <= rll_next;
      wcap_reg <= wcap_next;
      ncl_reg <= ncl_next;
      nch_reg <= nch_next;
      wwave_reg <= wwave_next;
      nwave_reg <= nwave_next;
      edge_reg <= edge_in;
      rd_reg <= rd_next;
      pin_reg <= pin_next;
      irqw_reg <= irqw_next;
      irqn_reg <= irqn_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    ce && wr_ens && bus.wdata[`CTW_B_WEN] && wst_reg == ctw_pkg::CTW_STOPPED;
  endsequence
  sequence s_loaded;
    wst_reg == ctw_pkg::CTW_COUNTING && wcnt_reg == {$past(rlh_reg), $past(rll_reg)}
      && wwave_reg == $past(sctl_reg.lvl_neg);
  endsequence

  start_load_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL14]
    s_start |=> s_loaded) else $error("wide start did not load reload value");
  stop_write_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL7]
    ce && wr_ens && !bus.wdata[`CTW_B_WEN] |=> wst_reg == ctw_pkg::CTW_STOPPED)
    else $error("wide timer kept running after stop");
  tout_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL2]
    ce && wtout_ev |=> wctl_reg.tout) else $error("wide timeout flag not set");
  cnt_irq_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL4]
    ce && wtout_ev && wctl_reg.cnt_ie |=> irq_wide == $past(gie))
    else $error("wide count interrupt wrong");
  cap_irq_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL3]
    ce && wcap_ev && wctl_reg.cap_ie && gie |=> irq_wide && wcap_reg == $past(wcnt_reg))
    else $error("wide capture or interrupt wrong");
  edge_once_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL1]
    ce && wst_reg == ctw_pkg::CTW_LATCHED && sctl_reg.demod && (pos_e || neg_e)
      |=> $stable(wcap_reg)) else $error("edge not ignored");
  single_stop_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL16]
    ce && wtout_ev && !wctl_reg.modulo && !sctl_reg.demod |=> wst_reg == ctw_pkg::CTW_STOPPED)
    else $error("single pass did not stop");
  force_out_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL13]
    ce && wctl_reg.pin_sel && sctl_reg.force_out[1] |=> pin_out[1] == $past(sctl_reg.force_out[0]))
    else $error("forced output level wrong");
  idle_level_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL12]
    ce && wctl_reg.pin_sel && !sctl_reg.force_out[1] && !sctl_reg.demod
      && wst_reg == ctw_pkg::CTW_STOPPED |=> pin_out[1] == !$past(sctl_reg.lvl_neg))
    else $error("idle output level wrong");
  narrow_cap_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL10]
    ce && ncap_pos |=> ncl_reg == $past(ncnt_reg) && ncnt_reg == `CTW_N_RELOAD && sctl_reg.pos_st)
    else $error("narrow positive capture wrong");
  narrow_wrap_a: assert property (@(posedge clk) disable iff (!rst_n) // [RL11]
    ce && nwrap_ev |=> nctl_reg.tout && ncnt_reg == `CTW_N_RELOAD)
    else $error("narrow wrap wrong");
endmodule

// >>> hw/ctw_map.svh
// Purpose: Register offsets, bit positions and fixed values of the timer block
// Assumes: Included by bare name from the design files
// Notes: Definitions only
`ifndef CTW_MAP_SVH
`define CTW_MAP_SVH

// Register offsets in the expanded bank
`define CTW_A_NCTL 4'h0
`define CTW_A_SCTL 4'h1
`define CTW_A_WCTL 4'h2
`define CTW_A_ENS 4'h3
`define CTW_A_RLH 4'h4
`define CTW_A_RLL 4'h5
`define CTW_A_WCL 4'h6
`define CTW_A_WCH 4'h7
`define CTW_A_NCL 4'h8
`define CTW_A_NCH 4'h9

// Bit positions
`define CTW_B_WEN 7
`define CTW_B_NEN 6
`define CTW_B_SYNC 5
`define CTW_B_TOUT 5
`define CTW_B_POS 1
`define CTW_B_NEG 0

// Values
`define CTW_N_RELOAD 8'hFF
`define CTW_N_ZERO8 8'h00
`define CTW_N_ZERO16 16'h0000
`define CTW_N_ENS_LOW 5'h00
`define CTW_N_DIV0 3'h0

// Route codes for the shared output pin
`define CTW_R_PORT 2'h0
`define CTW_R_NARROW 2'h1
`define CTW_R_WIDE 2'h2
`define CTW_R_BOTH 2'h3

`endif

// >>> hw/ctw_pkg.sv
// Purpose: Types shared by the timer block
// Assumes: Field order matches the register bit order, D7 first
// Notes: Reserved fields are never written and read as zero
package ctw_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } ctw_bus_t;

  typedef struct packed {
    logic modulo;
    logic edge_once;
    logic tout;
    logic [1:0] clk_sel;
    logic cap_ie;
    logic cnt_ie;
    logic pin_sel;
  } ctw_wide_ctl_t;

  typedef struct packed {
    logic demod;
    logic alt;
    logic [1:0] route;
    logic [1:0] force_out;
    logic pos_st;
    logic lvl_neg;
  } ctw_shared_ctl_t;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic tout;
    logic [1:0] rsv_lo;
    logic cap_ie;
    logic tout_ie;
    logic pin_sel;
  } ctw_narrow_ctl_t;

  typedef enum logic [1:0] {CTW_STOPPED, CTW_COUNTING, CTW_LATCHED} ctw_run_t;

endpackage

// >>> hw/ctw_tick.sv
// Purpose: Count-rate prescaler for the wide timer
// Assumes: sel picks divide by 1, 2, 4 or 8
// Notes: Restarts from zero whenever run is low
`timescale 1ns/1ps
`include "ctw_map.svh"
module ctw_tick (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset
  input wire logic ce, // Clock enable
  input wire logic run, // Counter running
  input wire logic [1:0] sel, // Rate select
  output logic tick // Count strobe
);
  logic [2:0] div_reg;
  logic [2:0] div_next;
  logic [2:0] mask;

  always_comb begin
    mask = (3'h1 << sel) - 3'h1;
    tick = run && ((div_reg & mask) == mask);
    div_next = run ? div_reg + 3'h1 : `CTW_N_DIV0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= `CTW_N_DIV0;
    end else if (ce) begin
      div_reg <= div_next;
    end
  end
endmodule

// >>> verif/ctw_pin_model.sv
// Purpose: Far-side pin model, the edge source and the ordinary port values
// Assumes: flip is a one-cycle request from the bench
// Notes: Port values change every cycle so a stale pin level shows up
`timescale 1ns/1ps
module ctw_pin_model (
  input wire logic clk, // System clock
  input wire logic flip, // Toggle request for the edge line
  output logic edge_in, // Edge line towards the timer
  output logic [2:0] port_val // Ordinary port values
);
  initial begin
    edge_in = 1'b0;
    port_val = 3'h0;
  end
  always @(posedge clk) begin
    port_val <= port_val + 3'h3;
    if (flip) begin
      edge_in <= ~edge_in;
    end
  end
endmodule

// >>> verif/dual_counter_timer_transmit_demod_bench.sv
// Purpose: Self-checking bench for the dual counter/timer
// Assumes: Clock enable held high, wide divider restarts on each start
// Notes: Interval checks use the cycle counter, timeout comes one tick after zero
`timescale 1ns/1ps
module dual_counter_timer_transmit_demod_bench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic gie = 1'b1;
  logic flip = 1'b0;
  logic edge_in;
  logic [2:0] port_val, pv_d, pin_out;
  logic [7:0] rdata, v, c1, c2;
  logic [7:0] cap [2];
  logic irq_wide, irq_narrow;
  ctw_pkg::ctw_bus_t bus = '0;
  int bad_count = 0, tests_run = 0, seed = 30200;
  int cyc = 0, last = 0, gap = 0, nw = 0, nn = 0;
  int t, n, k, d, wb, nb;
  always #10 clk = ~clk;
  ctw_dual_timer ctw_dual_timer_inst (.clk(clk), .arst_n(arst_n), .ce(1'b1), .bus(bus),
    .rdata(rdata), .edge_in(edge_in), .port_val(port_val), .gie(gie), .pin_out(pin_out),
    .irq_wide(irq_wide), .irq_narrow(irq_narrow));
  ctw_pin_model ctw_pin_model_inst (.clk(clk), .flip(flip), .edge_in(edge_in),
    .port_val(port_val));
  always @(posedge clk) begin
    cyc++;
    pv_d = port_val;
    if (irq_wide === 1'b1) begin
      nw++;
      gap = cyc - last;
      last = cyc;
    end
    if (irq_narrow === 1'b1) begin
      nn++;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One register access, then one idle cycle; read data lands in v
  task automatic op(input logic w, input logic [3:0] a, input logic [7:0] dat);
    bus <= '{wr: w, rd: ~w, addr: a, wdata: dat};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask
  task automatic wait_w(input int lim);
    t = -1;
    for (k = 1; k <= lim && t < 0; k++) begin
      @(negedge clk);
      if (k == 1) begin
        c1 = {5'h0, pin_out};
      end
      if (irq_wide === 1'b1) begin
        t = k;
      end
    end
    @(posedge clk);
  endtask
  task automatic end_sim;
    $display("Counts: %0d checks, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    bad_count++;
    end_sim;
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    op(0, 4'h3, 8'h00);
    chk(v, 8'h00);
    op(0, 4'hA, 8'h00);
    chk(v, 8'h00);
    op(1, 4'h3, 8'h20);
    op(0, 4'h3, 8'h00);
    chk(v, 8'h20);
    op(1, 4'h3, 8'h00);
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      chk(pin_out[0], pv_d[0]);
      chk(pin_out[1], pv_d[1]);
      chk(pin_out[2], pv_d[2]);
    end
    @(posedge clk);
    $display("Test registers and port pins done");
    op(1, 4'h2, 8'h01);
    for (int f = 0; f < 4; f++) begin
      op(1, 4'h1, f < 2 ? f[7:0] : 8'h20 | (f[7:0] << 2));
      @(negedge clk);
      chk(pin_out[1], f < 2 ? !f[0] : f[0]);
      if (f > 1) begin
        chk(pin_out[2], f[0]);
      end
      @(posedge clk);
    end
    $display("Test idle level and force done");
    for (int s = 0; s < 5; s++) begin
      n = 5 + ($random(seed) & 7);
      gie <= (s < 4);
      op(1, 4'h1, 8'h01);
      op(1, 4'h4, 8'h00);
      op(1, 4'h5, n[7:0]);
      op(1, 4'h2, {3'h0, s[1:0], 3'h3});
      op(1, 4'h3, 8'h80);
      wait_w(200);
      d = (n + 1) << s[1:0];
      chk(s < 4 ? (t == d) : (t < 0), 1'b1);
      chk(c1[1], 1'b1);
      op(0, 4'h3, 8'h00);
      chk(v[7], 1'b0);
      op(0, 4'h2, 8'h00);
      chk(v[5], 1'b1);
      op(1, 4'h2, 8'h20);
      op(0, 4'h2, 8'h00);
      chk(v[5], 1'b0);
    end
    $display("Test single pass done");
    gie <= 1'b1;
    op(1, 4'h4, 8'h01);
    op(1, 4'h5, 8'h03);
    op(1, 4'h2, 8'h83);
    op(1, 4'h3, 8'h80);
    wait_w(400);
    @(negedge clk);
    c2 = {5'h0, pin_out};
    op(1, 4'h4, 8'h00);
    op(1, 4'h5, 8'h05);
    wait_w(400);
    @(negedge clk);
    chk(gap, 16'd260);
    chk(pin_out[1], !c2[1]);
    wait_w(20);
    @(negedge clk);
    chk(gap, 16'd6);
    @(posedge clk);
    $display("Test modulo reload done");
    op(1, 4'h3, 8'h00);
    op(1, 4'h4, 8'hFF);
    op(1, 4'h0, 8'h04);
    for (int e = 0; e < 2; e++) begin
      op(1, 4'h1, 8'h80);
      op(1, 4'h1, 8'h83);
      op(1, 4'h2, e ? 8'h04 : 8'h44);
      op(1, 4'h3, 8'hC0);
      op(0, 4'h3, 8'h00);
      chk(v[7:5], 3'h6);
      wb = nw;
      nb = nn;
      for (int j = 0; j < 2; j++) begin
        repeat ((j ? 3 : 20) + ($random(seed) & 7)) @(posedge clk);
        flip <= 1'b1;
        @(posedge clk);
        flip <= 1'b0;
        repeat (4) @(posedge clk);
        op(0, 4'h6, 8'h00);
        cap[j] = v;
        op(0, 4'h1, 8'h00);
        chk(v[1:0], j ? 2'h3 : 2'h2);
        chk(nn - nb, j + 1);
      end
      chk(cap[0] === cap[1], !e);
      chk(nw - wb, e ? 2 : 1);
      op(0, 4'h9, 8'h00);
      chk(v >= 8'hE0, 1'b1);
      op(1, 4'h3, 8'h00);
    end
    op(1, 4'h3, 8'h40);
    repeat (300) @(posedge clk);
    op(0, 4'h0, 8'h00);
    chk(v[5], 1'b1);
    $display("Test demodulation done");
    end_sim;
  end
endmodule
